// file: common/vic_pkg.sv
`default_nettype none
package vic_pkg;
	// source ranks; rank 15 is left empty
	localparam int NUM_RANKS = 23;
	localparam int RANK_PIN0 = 0;
	localparam int RANK_TMR0 = 1;
	localparam int RANK_PIN1 = 2;
	localparam int RANK_TMR1 = 3;
	localparam int RANK_UART = 4;
	localparam int RANK_TMR2 = 5;
	localparam int RANK_SPI = 6;
	localparam int RANK_TWI = 7;
	localparam int RANK_ALARM = 8;
	localparam int RANK_WIN = 9;
	localparam int RANK_EOC = 10;
	localparam int RANK_PCA = 11;
	localparam int RANK_XMID = 12;
	localparam int RANK_XEND = 13;
	localparam int RANK_TMR3 = 14;
	localparam int RANK_HOLE = 15;
	localparam int RANK_MATCH = 16;
	localparam int RANK_OSC = 17;
	localparam int RANK_MAC = 18;
	localparam int RANK_CSCPT = 19;
	localparam int RANK_CSDC = 20;
	localparam int RANK_CSEOS = 21;
	localparam int RANK_TWS = 22;
	// vectors
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	// base enable register
	localparam logic [7:0] IE_BASE_ADDR = 8'ha8;
	localparam logic [7:0] IE_BASE_RESET = 8'h00;
	localparam int IE_GLOBAL_BIT = 7;
	localparam int NUM_BASE = 7;
	// call timing: one cycle detect, four to finish the call
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES = 4;
	localparam logic [2:0] CALL_CNT = 3'(CALL_CYCLES);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALL = 2'b01,
		ST_GAP = 2'b10
	} vic_state_e;

	// pending sources grouped
	typedef struct packed {
		logic pinZeroPending;
		logic timerZeroOverflow;
		logic pinOnePending;
		logic timerOneOverflow;
		logic serialRxDone;
		logic serialTxDone;
		logic timerTwoHighOverflow;
		logic timerTwoLowOverflow;
		logic [3:0] spiFlags;
		logic twowireEvent;
		logic alarm;
		logic windowCompare;
		logic endOfConversion;
		logic counterArrayOverflow;
		logic [2:0] counterChannelEvent;
		logic [6:0] xferChannelMidpoint;
		logic [6:0] xferChannelEndpoint;
		logic timerThreeHighOverflow;
		logic timerThreeLowOverflow;
		logic portMatch;
		logic clockOscFailure;
		logic macDone;
		logic csConvDone;
		logic csCompare;
		logic csEndOfScan;
		logic twowireSlaveEvent;
	} vic_flags_s;

	// core handshake
	typedef struct packed {
		logic instrDone;
		logic retiDone;
	} vic_core_s;

	function automatic logic [15:0] vicVector(input logic [4:0] rank);
		vicVector = VEC_BASE + 16'(rank) * VEC_STEP;
	endfunction
endpackage
`default_nettype wire

// file: rtl/vic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module vic_arbiter
	import vic_pkg::*;
#(
	parameter int N = NUM_RANKS
) (
	// requests
	input wire logic [N-1:0] req,
	input wire logic [N-1:0] prio,
	// pick
	output logic found,
	output logic foundHigh,
	output logic [4:0] rank
);
	initial begin
		if (N < 1 || N > 32) $error("vic_arbiter: N out of range");
	end
	// high level first, then lowest rank
	always_comb begin
		found = 1'b0;
		foundHigh = 1'b0;
		rank = 5'h00;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && !prio[i] && !foundHigh) begin
				found = 1'b1;
				rank = 5'(i);
			end
		end
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && prio[i]) begin
				found = 1'b1;
				foundHigh = 1'b1;
				rank = 5'(i);
			end
		end
	end
endmodule // vic_arbiter
`default_nettype wire

// file: rtl/vic_controller.sv
`timescale 1ns/1ps
`default_nettype none
module vic_controller
	import vic_pkg::*;
#(
	parameter int NUM_BASE_SRC = NUM_BASE
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	input wire logic clockEn,
	// peripheral pending flags (hardware or software set)
	input wire vic_flags_s flags,
	// register port for base enable
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regBitWrite,
	input wire logic [2:0] regBitSel,
	input wire logic regBitVal,
	output logic [7:0] regRdata,
	// other enable and priority registers, held outside
	input wire logic [7:0] basePriorityReg,
	input wire logic [7:0] extEnableFirst,
	input wire logic [7:0] extEnableSecond,
	input wire logic [7:0] extPriorityFirst,
	input wire logic [7:0] extPrioritySecond,
	// core
	input wire vic_core_s core,
	output logic callReq,
	output logic [15:0] callVector,
	output logic resetVector,
	output logic clearPinZero,
	output logic clearTimerZero,
	output logic clearPinOne,
	output logic clearTimerOne,
	output logic [7:0] ieBase,
	output logic inHighHandler,
	output logic inLowHandler
);
	initial begin
		if (NUM_BASE_SRC != NUM_BASE) $error("vic_controller: base source count fixed");
	end
	////////////////////////////////////////////////////////////////////////////
	// base enable register
	logic [7:0] ie_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ie_r <= IE_BASE_RESET;
		end else if (clockEn) begin
			if (regWrite && regAddr == IE_BASE_ADDR) begin
				ie_r <= regWdata;
			end else if (regBitWrite && regAddr == IE_BASE_ADDR) begin
				ie_r[regBitSel] <= regBitVal;
			end
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			regRdata <= 8'h00;
			ieBase <= IE_BASE_RESET;
		end else if (clockEn) begin
			regRdata <= (regAddr == IE_BASE_ADDR) ? ie_r : 8'h00;
			ieBase <= ie_r;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// request gathering
	logic [NUM_RANKS-1:0] pend;
	logic [NUM_RANKS-1:0] en;
	logic [NUM_RANKS-1:0] pri;
	logic [NUM_RANKS-1:0] req;
	always_comb begin
		pend = '0;
		pend[RANK_PIN0] = flags.pinZeroPending;
		pend[RANK_TMR0] = flags.timerZeroOverflow;
		pend[RANK_PIN1] = flags.pinOnePending;
		pend[RANK_TMR1] = flags.timerOneOverflow;
		pend[RANK_UART] = flags.serialRxDone | flags.serialTxDone;
		pend[RANK_TMR2] = flags.timerTwoHighOverflow | flags.timerTwoLowOverflow;
		pend[RANK_SPI] = |flags.spiFlags;
		pend[RANK_TWI] = flags.twowireEvent;
		pend[RANK_ALARM] = flags.alarm;
		pend[RANK_WIN] = flags.windowCompare;
		pend[RANK_EOC] = flags.endOfConversion;
		pend[RANK_PCA] = flags.counterArrayOverflow | (|flags.counterChannelEvent);
		pend[RANK_XMID] = |flags.xferChannelMidpoint;
		pend[RANK_XEND] = |flags.xferChannelEndpoint;
		pend[RANK_TMR3] = flags.timerThreeHighOverflow | flags.timerThreeLowOverflow;
		pend[RANK_HOLE] = 1'b0;
		pend[RANK_MATCH] = flags.portMatch;
		pend[RANK_OSC] = flags.clockOscFailure;
		pend[RANK_MAC] = flags.macDone;
		pend[RANK_CSCPT] = flags.csConvDone;
		pend[RANK_CSDC] = flags.csCompare;
		pend[RANK_CSEOS] = flags.csEndOfScan;
		pend[RANK_TWS] = flags.twowireSlaveEvent;
	end
	// enables: base bits 0..6, first extended at 7..14, second extended bit n at 15+n
	always_comb begin
		en = '0;
		pri = '0;
		en[NUM_BASE-1:0] = ie_r[NUM_BASE-1:0];
		pri[NUM_BASE-1:0] = basePriorityReg[NUM_BASE-1:0];
		en[RANK_TMR3:RANK_TWI] = extEnableFirst;
		pri[RANK_TMR3:RANK_TWI] = extPriorityFirst;
		en[RANK_TWS:RANK_MATCH] = extEnableSecond[7:1];
		pri[RANK_TWS:RANK_MATCH] = extPrioritySecond[7:1];
		// flags are taken as given; enable only gates the request
		req = pend & en & {NUM_RANKS{ie_r[IE_GLOBAL_BIT]}};
	end
	////////////////////////////////////////////////////////////////////////////
	// arbitration, every clock
	logic found;
	logic foundHigh;
	logic [4:0] rank;
	vic_arbiter #(.N(NUM_RANKS)) arb (
		.req(req),
		.prio(pri),
		.found(found),
		.foundHigh(foundHigh),
		.rank(rank)
	);
	////////////////////////////////////////////////////////////////////////////
	// call sequencing
	vic_state_e state_r;
	logic [2:0] cnt_r;
	logic [4:0] rankHeld_r;
	logic highHeld_r;
	logic highAct_r;
	logic lowAct_r;
	logic mayTake;
	// high preempts low; nothing preempts high
	always_comb begin
		mayTake = found && !highAct_r && (foundHigh || !lowAct_r);
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			rankHeld_r <= 5'h00;
			highHeld_r <= 1'b0;
		end else if (clockEn) begin
			case (state_r)
				ST_IDLE: begin
					if (mayTake) begin
						state_r <= ST_CALL;
						cnt_r <= CALL_CNT - 3'h1;
						rankHeld_r <= rank;
						highHeld_r <= foundHigh;
					end
				end
				ST_CALL: begin
					if (cnt_r == 3'h0) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				ST_GAP: begin
					// one instruction must finish before the next call
					if (core.instrDone) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
			if (core.retiDone && state_r != ST_CALL) begin
				state_r <= ST_GAP;
			end
		end
	end
	// active handler levels, released on return
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			highAct_r <= 1'b0;
			lowAct_r <= 1'b0;
		end else if (clockEn) begin
			if (state_r == ST_CALL && cnt_r == 3'h0) begin
				if (highHeld_r) begin
					highAct_r <= 1'b1;
				end else begin
					lowAct_r <= 1'b1;
				end
			end else if (core.retiDone) begin
				if (highAct_r) begin
					highAct_r <= 1'b0;
				end else begin
					lowAct_r <= 1'b0;
				end
			end
		end
	end
	// outputs to core; reset vector shown while held in reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			callReq <= 1'b0;
			callVector <= VEC_RESET;
			resetVector <= 1'b1;
			clearPinZero <= 1'b0;
			clearTimerZero <= 1'b0;
			clearPinOne <= 1'b0;
			clearTimerOne <= 1'b0;
			inHighHandler <= 1'b0;
			inLowHandler <= 1'b0;
		end else if (clockEn) begin
			resetVector <= 1'b0;
			clearPinZero <= 1'b0;
			clearTimerZero <= 1'b0;
			clearPinOne <= 1'b0;
			clearTimerOne <= 1'b0;
			callReq <= 1'b0;
			inHighHandler <= highAct_r;
			inLowHandler <= lowAct_r;
			if (state_r == ST_CALL && cnt_r == 3'h0) begin
				callReq <= 1'b1;
				callVector <= vicVector(rankHeld_r);
				// only the first four sources clear on vectoring
				clearPinZero <= rankHeld_r == 5'(RANK_PIN0);
				clearTimerZero <= rankHeld_r == 5'(RANK_TMR0);
				clearPinOne <= rankHeld_r == 5'(RANK_PIN1);
				clearTimerOne <= rankHeld_r == 5'(RANK_TMR1);
			end
		end
	end
endmodule // vic_controller
`default_nettype wire

// file: bench/vic_controller_chk.sv
`timescale 1ns/1ps
`default_nettype none
module vic_controller_chk (
	// watched ports
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regRdata,
	input wire logic [7:0] ieBase,
	input wire logic callReq,
	input wire logic [15:0] callVector,
	input wire logic resetVector,
	input wire logic clearPinZero,
	input wire logic clearTimerOne,
	input wire logic inHighHandler,
	input wire logic inLowHandler
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	sequence s_call; callReq; endsequence
	sequence s_gap; !callReq [*4]; endsequence
	property p_pin0Clr; clearPinZero |-> callReq && callVector == 16'h0003; endproperty
	a_pin0Clr: assert property (p_pin0Clr) else $error("pin zero clear off its call");
	property p_tmr1Clr; clearTimerOne |-> callReq && callVector == 16'h001b; endproperty
	a_tmr1Clr: assert property (p_tmr1Clr) else $error("timer one clear off its call");
	property p_gap; s_call |=> s_gap; endproperty
	a_gap: assert property (p_gap) else $error("calls closer than detect plus call");
	// ieBase lags the register by one cycle, hence six cycles
	property p_global; !ieBase[7] [*6] |-> !callReq; endproperty
	a_global: assert property (p_global) else $error("call with global enable off");
	property p_rstVec; resetVector |=> !resetVector; endproperty
	a_rstVec: assert property (p_rstVec) else $error("reset vector held too long");
	property p_read; 1'b1 |=> regRdata == (($past(regAddr) == 8'ha8) ? ieBase : 8'h00); endproperty
	a_read: assert property (p_read) else $error("read data mismatch");
	property p_level; s_call |=> inHighHandler || inLowHandler; endproperty
	a_level: assert property (p_level) else $error("no handler level after call");
	property p_noCall; inHighHandler && $past(inHighHandler) |-> !callReq; endproperty
	a_noCall: assert property (p_noCall) else $error("call inside high handler");
endmodule // vic_controller_chk
`default_nettype wire

// file: bench/vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
	import vic_pkg::*;
#(
	parameter int HLEN = 30
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// controller side
	input wire logic callReq,
	output var vic_core_s core
);
	logic [7:0] tmr;
	logic [1:0] depth, ph;
	// nested calls return one by one, newest first
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tmr <= 8'h00;
			depth <= 2'h0;
			ph <= 2'h0;
			core <= '0;
		end else begin
			ph <= ph + 2'h1;
			core.instrDone <= (ph == 2'h3);
			core.retiDone <= 1'b0;
			if (callReq) begin
				depth <= depth + 2'h1;
				tmr <= 8'(HLEN);
			end else if (depth != 2'h0 && tmr == 8'h01) begin
				core.retiDone <= 1'b1;
				depth <= depth - 2'h1;
				tmr <= 8'(HLEN);
			end else if (tmr != 8'h00) begin
				tmr <= tmr - 8'h01;
			end
		end
	end
endmodule // vic_core_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import vic_pkg::*;
;
	logic clock = 1'b0, nrst = 1'b0, clockEn = 1'b1, regWrite = 1'b0, regBitWrite = 1'b0, regBitVal = 1'b0;
	logic [2:0] regBitSel = 3'h7;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, basePriorityReg = 8'h00, regRdata, ieBase, rdv;
	logic [7:0] extEnableFirst = 8'h00, extEnableSecond = 8'h00, extPriorityFirst = 8'h00, extPrioritySecond = 8'h00;
	vic_flags_s flags = '0;
	vic_core_s core;
	logic callReq, resetVector, clearPinZero, clearTimerZero, clearPinOne, clearTimerOne, inHighHandler, inLowHandler;
	logic [15:0] callVector;
	int bad_count = 0, check_count = 0, n;
	int fbit [23] = '{42, 41, 40, 39, 37, 35, 31, 30, 29, 28, 27, 23, 22, 9, 7, 0, 6, 5, 4, 3, 2, 1, 0};
	int mbit [4] = '{39, 41, 40, 39};
	logic [7:0] mie [4] = '{8'hf7, 8'hfd, 8'hfb, 8'h7f};
	int pa [4] = '{42, 42, 42, 41};
	int pb [4] = '{31, 41, 30, 39};
	logic [7:0] pie [4] = '{8'hc1, 8'h83, 8'h81, 8'h8a};
	logic [7:0] pbp [4] = '{8'h40, 8'h00, 8'h00, 8'h08};
	logic [15:0] pv [4] = '{16'h0033, 16'h0003, 16'h003b, 16'h001b};
	always #2.5 clock = ~clock;
	vic_controller i_dut (.clock, .nrst, .clockEn, .flags, .regAddr, .regWdata, .regWrite, .regBitWrite, .regBitSel,
		.regBitVal, .regRdata, .basePriorityReg, .extEnableFirst, .extEnableSecond, .extPriorityFirst,
		.extPrioritySecond, .core, .callReq, .callVector, .resetVector, .clearPinZero, .clearTimerZero,
		.clearPinOne, .clearTimerOne, .ieBase, .inHighHandler, .inLowHandler);
	vic_core_model i_core (.clock, .nrst, .callReq, .core);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		@(posedge clock);
		#1 rdv = regRdata;
	endtask
	// n ends as edges from flag to call
	task automatic fire(input logic [42:0] f);
		@(posedge clock);
		flags <= vic_flags_s'(f);
		for (n = 0; !callReq; n++) begin
			@(posedge clock);
			#1;
			if (n > 80) begin
				chk("call", 16'h0001, 16'h0000);
				test_done();
			end
		end
	endtask
	// flags stay set unless the handler drops them
	// handler levels show one cycle after the call, so step past it first
	task automatic idle();
		@(posedge clock);
		flags <= '0;
		@(posedge clock);
		#1;
		for (n = 0; (inHighHandler || inLowHandler) && n < 300; n++) begin
			@(posedge clock);
			#1;
		end
		chk("idle", 16'h0000, {14'h0, inHighHandler, inLowHandler});
		repeat (8) @(posedge clock);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clock);
		chk("vector", 16'h0000, callVector);
		chk("resetVector", 16'h0001, {15'h0, resetVector});
		chk("ieBase", 16'h0000, {8'h00, ieBase});
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("resetVector", 16'h0000, {15'h0, resetVector});
		$display("reset test done");
		wr(8'ha8, 8'hff);
		rd(8'ha8);
		chk("ie", 16'h00ff, {8'h00, rdv});
		@(posedge clock);
		regBitWrite <= 1'b1;
		@(posedge clock);
		regBitWrite <= 1'b0;
		wr(8'h55, 8'h00);
		rd(8'ha8);
		chk("ie bit", 16'h007f, {8'h00, rdv});
		rd(8'h55);
		chk("unmapped", 16'h0000, {8'h00, rdv});
		$display("register test done");
		for (int r = 0; r < NUM_RANKS; r++) begin
			if (r != RANK_HOLE) begin
				extEnableFirst <= (r >= 7 && r <= 14) ? 8'h01 << (r - 7) : 8'h00;
				extEnableSecond <= (r >= 16) ? 8'h01 << (r - 15) : 8'h00;
				wr(8'ha8, (r < 7) ? 8'h80 | (8'h01 << r) : 8'h80);
				fire(43'h1 << fbit[r]);
				chk("latency", 16'h0005, 16'(n));
				chk("vector", 16'h0003 + 16'(r) * 16'h0008, callVector);
				chk("clears", 16'(r < 4 ? 4'h8 >> r : 4'h0), {12'h0, clearPinZero, clearTimerZero,
					clearPinOne, clearTimerOne});
				idle();
			end
		end
		$display("vector test done");
		for (int i = 0; i < 4; i++) begin
			flags <= '0;
			wr(8'ha8, mie[i]);
			@(posedge clock);
			flags <= vic_flags_s'(43'h1 << mbit[i]);
			n = 0;
			repeat (12) begin
				@(posedge clock);
				#1 n += int'(callReq);
			end
			chk("masked", 16'h0000, 16'(n));
		end
		wr(8'ha8, 8'h88);
		fire(43'h1 << 39);
		chk("late enable", 16'h001b, callVector);
		idle();
		$display("mask test done");
		for (int i = 0; i < 4; i++) begin
			basePriorityReg <= pbp[i];
			extEnableFirst <= 8'(i == 2);
			extPriorityFirst <= 8'(i == 2);
			wr(8'ha8, pie[i]);
			fire((43'h1 << pa[i]) | (43'h1 << pb[i]));
			chk("arbitrated", pv[i], callVector);
			idle();
		end
		basePriorityReg <= 8'h02;
		wr(8'ha8, 8'h86);
		fire(43'h1 << 40);
		@(posedge clock);
		flags <= '0;
		repeat (3) @(posedge clock);
		fire(43'h1 << 41);
		chk("preempt", 16'h000b, callVector);
		chk("low held", 16'h0001, {15'h0, inLowHandler});
		idle();
		$display("priority test done");
		basePriorityReg <= 8'h00;
		wr(8'ha8, 8'h90);
		fire(43'h1 << 37);
		rdv = 8'h00;
		for (n = 0; !core.retiDone && n < 80; n++) begin
			@(posedge clock);
			#1;
		end
		chk("reti", 16'h0001, {15'h0, core.retiDone});
		for (n = 0; !callReq && n < 40; n++) begin
			@(posedge clock);
			#1 rdv[0] = rdv[0] | core.instrDone;
		end
		chk("recall", 16'h0003, {14'h0, callReq, rdv[0]});
		idle();
		$display("return test done");
		// low enable freezes the register against writes
		clockEn <= 1'b0;
		wr(8'ha8, 8'h00);
		clockEn <= 1'b1;
		rd(8'ha8);
		chk("frozen", 16'h0090, {8'h00, rdv});
		$display("freeze test done");
		test_done();
	end
endmodule // testbench
bind vic_controller vic_controller_chk i_chk (.clock, .nrst, .regAddr, .regRdata, .ieBase, .callReq, .callVector,
	.resetVector, .clearPinZero, .clearTimerOne, .inHighHandler, .inLowHandler);
`default_nettype wire
